// ### dv/flash_program_erase_guard_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) \
	begin \
		num_checks++; \
		if ((a) !== (e)) \
		begin \
			error_cnt++; \
			$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); \
		end \
	end
module flash_program_erase_guard_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic por_n = 1'b0;
	logic wtr, rd_s, wr_s, stall, flash_error_device_reset, cv, dd, dr, hang;
	logic [31:0] rdat, wdat;
	logic [7:0] adr, cdat, ddat, q;
	logic v, f, x, r;
	fpg_pkg::fpg_external_data_ram_s external_data_ram;
	fpg_pkg::fpg_cpu_s cpu;
	fpg_pkg::fpg_dbg_s dbgq;
	int s;
	int error_cnt = 0;
	int num_checks = 0;

	// 200 MHz core clock
	always #2.5 clk = ~clk;

	fpg_top DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_POR_N(por_n), .I_AVS_ADDRESS(adr),
		.I_AVS_READ(rd_s), .I_AVS_WRITE(wr_s), .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat),
		.O_AVS_WAITREQUEST(wtr), .I_CPU(cpu), .I_DBG(dbgq), .O_CPU_STALL(stall), .O_EXTERNAL_DATA_RAM(external_data_ram),
		.O_CMOVE_RDATA(cdat), .O_CMOVE_VALID(cv), .O_DBG_DONE(dd), .O_DBG_REFUSED(dr),
		.O_DBG_RDATA(ddat), .O_FLASH_ERROR_DEVICE_RESET(flash_error_device_reset));
	fpg_fw_model u_fw (.i_clk(clk), .i_wait(wtr), .i_rdata(rdat), .i_stall(stall),
		.i_flash_error_device_reset(flash_error_device_reset), .i_cvalid(cv), .i_cdata(cdat), .i_external_data_ram(external_data_ram), .i_ddone(dd),
		.i_dref(dr), .i_ddata(ddat), .o_addr(adr), .o_rd(rd_s), .o_wr(wr_s), .o_wdata(wdat),
		.o_cpu(cpu), .o_dbg(dbgq), .o_hang(hang));

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	// Short wrappers; a flash error reset is played back as a system reset
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_fw.bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		u_fw.bus(1'b0, a, 8'h00, q);
	endtask : rd
	task automatic cr(input logic [15:0] pc, input logic [15:0] a);
		u_fw.mvr(1'b0, pc, a, q, v, f, x);
	endtask : cr
	task automatic mw(input logic [15:0] a, input logic [7:0] d);
		u_fw.mvw(a, d, s, f);
	endtask : mw
	task automatic keys(input int gap);
		wr(fpg_pkg::IDX_KEY, fpg_pkg::KEY_FIRST);
		repeat (gap) @(posedge clk);
		wr(fpg_pkg::IDX_KEY, fpg_pkg::KEY_SECOND);
	endtask : keys
	task automatic sysrst();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
	endtask : sysrst

	task automatic t_regs();
		rd(fpg_pkg::IDX_PROGRAM_STORE_CONTROL);
		`CHK(q, {6'h00, fpg_pkg::PROGRAM_STORE_CONTROL_RST})
		rd(fpg_pkg::IDX_SUPPLY);
		`CHK(q[1:0], fpg_pkg::SUPPLY_RST)
		wr(8'h10, 8'hff);
		rd(8'h10);
		`CHK(q, 8'h00)
		mw(16'h0040, 8'h33);
		cr(16'h0000, 16'h0040);
		`CHK({f, q}, {1'b0, fpg_pkg::ERASED})
		$display("regs test done");
	endtask : t_regs

	task automatic t_prog();
		wr(fpg_pkg::IDX_PROGRAM_STORE_CONTROL, 8'h01);
		keys(20);
		mw(16'h0010, 8'h5a);
		`CHK(s, 1 + fpg_pkg::PROG_CYCLES)
		cr(16'h0000, 16'h0010);
		`CHK(q, 8'h5a)
		rd(fpg_pkg::IDX_KEY);
		`CHK(q[1:0], fpg_pkg::KEY_LOCKED)
		rd(fpg_pkg::IDX_PROGRAM_STORE_CONTROL);
		`CHK(q, 8'h01)
		keys(0);
		mw(16'h0010, 8'h0f);
		cr(16'h0000, 16'h0010);
		`CHK(q, 8'h0a)
		u_fw.mvr(1'b1, 16'h0000, 16'h0123, q, v, f, x);
		`CHK({x, v}, 2'b10)
		$display("program test done");
	endtask : t_prog

	task automatic t_erase();
		keys(0);
		mw(16'h0200, 8'h00);
		wr(fpg_pkg::IDX_PROGRAM_STORE_CONTROL, 8'h03);
		keys(0);
		mw(16'h03ff, 8'h12);
		`CHK(s, fpg_pkg::PAGE_BYTES + 1)
		cr(16'h0000, 16'h0200);
		`CHK(q, fpg_pkg::ERASED)
		cr(16'h0000, 16'h0010);
		`CHK(q, 8'h0a)
		wr(fpg_pkg::IDX_PROGRAM_STORE_CONTROL, 8'h00);
		$display("erase test done");
	endtask : t_erase

	task automatic t_badkey();
		logic [7:0] bad [2];
		bad = '{8'h5a, fpg_pkg::KEY_SECOND};
		foreach (bad[i])
		begin
			wr(fpg_pkg::IDX_PROGRAM_STORE_CONTROL, 8'h01);
			wr(fpg_pkg::IDX_KEY, bad[i]);
			keys(0);
			rd(fpg_pkg::IDX_KEY);
			`CHK(q[1:0], fpg_pkg::KEY_DEAD)
			mw(16'h0020, 8'h00);
			`CHK(s, 0)
			sysrst();
			rd(fpg_pkg::IDX_KEY);
			`CHK(q[1:0], fpg_pkg::KEY_LOCKED)
		end
		wr(fpg_pkg::IDX_PROGRAM_STORE_CONTROL, 8'h01);
		mw(16'h0021, 8'h00);
		keys(0);
		rd(fpg_pkg::IDX_KEY);
		`CHK(q[1:0], fpg_pkg::KEY_DEAD)
		cr(16'h0000, 16'h0021);
		`CHK(q, fpg_pkg::ERASED)
		sysrst();
		$display("key test done");
	endtask : t_badkey

	task automatic t_supply();
		for (int i = 0; i < 3; i++)
		begin
			wr(fpg_pkg::IDX_SUPPLY, 8'(i));
			wr(fpg_pkg::IDX_PROGRAM_STORE_CONTROL, 8'h01);
			keys(0);
			mw(16'h0030, 8'h00);
			`CHK(f, 1'b1)
			sysrst();
			rd(fpg_pkg::IDX_RESET_SOURCE_REGISTER);
			`CHK(q[0], 1'b1)
		end
		sysrst();
		rd(fpg_pkg::IDX_RESET_SOURCE_REGISTER);
		`CHK(q[0], 1'b0)
		$display("supply test done");
	endtask : t_supply

	task automatic t_lock();
		wr(fpg_pkg::IDX_PROGRAM_STORE_CONTROL, 8'h01);
		keys(0);
		mw(16'h07ff, 8'h7f);
		rd(fpg_pkg::IDX_STATUS);
		`CHK({f, q[1]}, 2'b00)
		sysrst();
		rd(fpg_pkg::IDX_STATUS);
		`CHK(q[1], 1'b1)
		cr(16'h0100, 16'h0010);
		`CHK({v, f}, 2'b10)
		cr(16'hf000, 16'h0010);
		`CHK(f, 1'b1)
		sysrst();
		cr(16'h0100, 16'h0900);
		`CHK(f, 1'b1)
		sysrst();
		wr(fpg_pkg::IDX_PROGRAM_STORE_CONTROL, 8'h01);
		keys(0);
		mw(16'h07ff, 8'h00);
		`CHK(f, 1'b1)
		sysrst();
		wr(fpg_pkg::IDX_PROGRAM_STORE_CONTROL, 8'h03);
		keys(0);
		mw(16'h0600, 8'h00);
		`CHK(f, 1'b1)
		sysrst();
		u_fw.dbg(fpg_pkg::DBG_READ, 16'h0010, q, r, f);
		`CHK({r, f}, 2'b10)
		u_fw.dbg(fpg_pkg::DBG_ERASE, 16'h0600, q, r, f);
		`CHK({r, f}, 2'b10)
		u_fw.dbg(fpg_pkg::DBG_WRITE, 16'h0900, q, r, f);
		`CHK({r, f}, 2'b10)
		u_fw.dbg(fpg_pkg::DBG_DEVERASE, 16'h0000, q, r, f);
		`CHK(r, 1'b0)
		u_fw.dbg(fpg_pkg::DBG_READ, 16'h07ff, q, r, f);
		`CHK({r, q}, {1'b0, fpg_pkg::ERASED})
		u_fw.dbg(fpg_pkg::DBG_WRITE, 16'h0050, q, r, f);
		cr(16'h0000, 16'h0050);
		`CHK({r, q}, 9'h000)
		$display("lock test done");
	endtask : t_lock

	// A wait that ran out ends the run
	always @(posedge clk)
	begin
		if (hang === 1'b1)
		begin
			error_cnt++;
			final_report();
		end
	end

	// Overall run limit, well above the expected length
	initial
	begin
		#400000;
		error_cnt++;
		final_report();
	end

	// Main sequence after the opening reset
	initial
	begin
		repeat (2) @(posedge clk);
		por_n <= 1'b1;
		rst_n <= 1'b1;
		t_regs();
		t_prog();
		t_erase();
		t_badkey();
		t_supply();
		t_lock();
		final_report();
	end
endmodule : flash_program_erase_guard_tb

// ### dv/fpg_fw_model.sv
`timescale 1ns/1ps
// Firmware and debug port stand-in; requests launch just after an edge
module fpg_fw_model (
	input  wire logic               i_clk,    // Core clock
	input  wire logic               i_wait,   // Bus stall
	input  wire logic [31:0]        i_rdata,  // Bus read data
	input  wire logic               i_stall,  // CPU stall
	input  wire logic               i_flash_error_device_reset,   // Error reset request
	input  wire logic               i_cvalid, // Code read valid
	input  wire logic [7:0]         i_cdata,  // Code read data
	input  wire fpg_pkg::fpg_external_data_ram_s i_external_data_ram,   // Data RAM access
	input  wire logic               i_ddone,  // Debug done
	input  wire logic               i_dref,   // Debug refused
	input  wire logic [7:0]         i_ddata,  // Debug read data
	output logic      [7:0]         o_addr,   // Bus word index
	output logic                    o_rd,     // Bus read
	output logic                    o_wr,     // Bus write
	output logic      [31:0]        o_wdata,  // Bus write data
	output fpg_pkg::fpg_cpu_s       o_cpu,    // Move requests
	output fpg_pkg::fpg_dbg_s       o_dbg,    // Debug request
	output logic                    o_hang    // A wait ran out
);
	// Idle values at time zero
	initial
	begin
		o_addr = 8'h00;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 32'h0;
		o_cpu = '0;
		o_dbg = '0;
		o_hang = 1'b0;
	end

	// Held until the edge that sees the stall low; data is scrambled after
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge i_clk);
		o_rd <= !w;
		o_wr <= w;
		o_addr <= a;
		o_wdata <= {24'h0, d};
		for (n = 0; n < 50; n++)
		begin
			@(posedge i_clk);
			if (!i_wait)
				break;
		end
		o_hang <= o_hang | (n == 50);
		q = i_rdata[7:0];
		o_rd <= 1'b0;
		o_wr <= 1'b0;
		o_wdata <= ~o_wdata;
	endtask : bus

	// One move write, then count stall cycles and note any error request
	task automatic mvw(input logic [15:0] a, input logic [7:0] d, output int s, output logic f);
		@(posedge i_clk);
		o_cpu.xwr <= 1'b1;
		o_cpu.addr <= a;
		o_cpu.data <= d;
		@(posedge i_clk);
		o_cpu.xwr <= 1'b0;
		s = 0;
		f = 1'b0;
		for (int n = 0; n < 1000; n++)
		begin
			@(posedge i_clk);
			f |= i_flash_error_device_reset;
			if (!i_stall)
				break;
			s++;
		end
		o_hang <= o_hang | (s == 1000);
	endtask : mvw

	// Code or external move read; answer looked at in the cycle after
	task automatic mvr(input logic ext, input logic [15:0] pc, input logic [15:0] a,
		output logic [7:0] q, output logic v, output logic f, output logic x);
		@(posedge i_clk);
		o_cpu.crd <= !ext;
		o_cpu.xrd <= ext;
		o_cpu.pc <= pc;
		o_cpu.addr <= a;
		@(posedge i_clk);
		o_cpu.crd <= 1'b0;
		o_cpu.xrd <= 1'b0;
		@(posedge i_clk);
		q = i_cdata;
		v = i_cvalid;
		f = i_flash_error_device_reset;
		x = i_external_data_ram.rd && (i_external_data_ram.addr === a);
	endtask : mvr

	// Debug request held until done, dropped at that edge
	task automatic dbg(input fpg_pkg::fpg_dbg_cmd_e c, input logic [15:0] a,
		output logic [7:0] q, output logic r, output logic f);
		int n;
		@(posedge i_clk);
		o_dbg.req <= 1'b1;
		o_dbg.cmd <= c;
		o_dbg.addr <= a;
		o_dbg.data <= 8'h00;
		f = 1'b0;
		for (n = 0; n < 5000; n++)
		begin
			@(posedge i_clk);
			f |= i_flash_error_device_reset;
			if (i_ddone)
				break;
		end
		o_hang <= o_hang | (n == 5000);
		q = i_ddata;
		r = i_dref;
		o_dbg.req <= 1'b0;
	endtask : dbg
endmodule : fpg_fw_model

// ### src/fpg_flash_array.sv
`timescale 1ns/1ps
module fpg_flash_array #(
	parameter int BYTES    = 2560,
	parameter int LOCK_IDX = 2047
) (
	input  wire logic                      i_clk,       // Core clock
	input  wire logic                      i_por_n,     // Power-on reset, low
	input  wire fpg_pkg::fpg_fwr_s         i_wr,        // Byte write port
	input  wire logic [fpg_pkg::FL_AW-1:0] i_rd_addr,   // Read address
	output logic      [7:0]                o_rd_data,   // Read data
	output logic      [7:0]                o_lock_byte  // Lock byte contents
);

	typedef struct packed {
		logic [BYTES-1:0][7:0] mem;
	} fpga_state_s;

	fpga_state_s s_q;
	fpga_state_s s_d;

	// Plain store; the sequencer already merged old and new bits
	always_comb
	begin
		s_d = s_q;
		if (i_wr.en && (int'(i_wr.addr) < BYTES))
		begin
			s_d.mem[i_wr.addr] = i_wr.data;
		end
	end

	// Power-on leaves a blank part; a system reset never touches contents
	always_ff @(posedge i_clk)
	begin
		if (!i_por_n)
			s_q <= '1;
		else
			s_q <= s_d;
	end

	assign o_rd_data   = (int'(i_rd_addr) < BYTES) ? s_q.mem[i_rd_addr] : fpg_pkg::ERASED;
	assign o_lock_byte = s_q.mem[LOCK_IDX];

endmodule : fpg_flash_array

// ### src/fpg_pkg.sv
package fpg_pkg;

	// Flash geometry and key codes
	localparam int        PAGE_BYTES  = 512;
	localparam int        FL_AW       = 12;
	localparam logic [7:0] KEY_FIRST  = 8'ha5;
	localparam logic [7:0] KEY_SECOND = 8'hf1;
	localparam logic [7:0] ERASED     = 8'hff;

	// Register word indices; byte address is four times the index
	localparam logic [7:0] IDX_PROGRAM_STORE_CONTROL  = 8'h8f;
	localparam logic [7:0] IDX_KEY    = 8'h90;
	localparam logic [7:0] IDX_RESET_SOURCE_REGISTER = 8'h91;
	localparam logic [7:0] IDX_SUPPLY = 8'h92;
	localparam logic [7:0] IDX_STATUS = 8'h93;

	// Field positions and values after reset
	localparam int         WE_BIT     = 0;
	localparam int         EE_BIT     = 1;
	localparam int         MON_EN_BIT  = 0;
	localparam int         MON_RST_BIT = 1;
	localparam logic [1:0] PROGRAM_STORE_CONTROL_RST  = 2'h0;
	localparam logic [1:0] SUPPLY_RST = 2'h3;

	// Byte program time; the count rounds up to whole cycles
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PROG_TIME_NS  = 20;
	localparam int PROG_CYCLES   = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		KEY_LOCKED = 2'b00,
		KEY_HALF   = 2'b01,
		KEY_OPEN   = 2'b10,
		KEY_DEAD   = 2'b11
	} fpg_key_e;

	typedef enum logic [1:0] {
		OP_IDLE     = 2'b00,
		OP_PROG     = 2'b01,
		OP_ERASE    = 2'b10
	} fpg_op_e;

	typedef enum logic [1:0] {
		DBG_READ     = 2'b00,
		DBG_WRITE    = 2'b01,
		DBG_ERASE    = 2'b10,
		DBG_DEVERASE = 2'b11
	} fpg_dbg_cmd_e;

	// CPU side move requests, all from the core clock
	typedef struct packed {
		logic        xwr;
		logic        xrd;
		logic        crd;
		logic [15:0] addr;
		logic [7:0]  data;
		logic [15:0] pc;
	} fpg_cpu_s;

	// Debug programming port request
	typedef struct packed {
		logic         req;
		fpg_dbg_cmd_e cmd;
		logic [15:0]  addr;
		logic [7:0]   data;
	} fpg_dbg_s;

	// Access to external data RAM
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  data;
	} fpg_external_data_ram_s;

	// Write port of the flash array
	typedef struct packed {
		logic             en;
		logic [FL_AW-1:0] addr;
		logic [7:0]       data;
	} fpg_fwr_s;

endpackage : fpg_pkg

// ### src/fpg_top.sv
`timescale 1ns/1ps
module fpg_top #(
	parameter int USER_PAGES = 4
) (
	input  wire logic                 I_CORE_CLK,        // Core clock, 200 MHz
	input  wire logic                 I_RST_N,           // System reset, sync, low
	input  wire logic                 I_POR_N,           // Power-on reset, sync, low
	input  wire logic [7:0]           I_AVS_ADDRESS,     // Register word index
	input  wire logic                 I_AVS_READ,        // Register read
	input  wire logic                 I_AVS_WRITE,       // Register write
	input  wire logic [31:0]          I_AVS_WRITEDATA,   // Register write data
	output logic      [31:0]          O_AVS_READDATA,    // Register read data
	output logic                      O_AVS_WAITREQUEST, // Bus stall
	input  wire fpg_pkg::fpg_cpu_s    I_CPU,             // CPU move requests
	input  wire fpg_pkg::fpg_dbg_s    I_DBG,             // Debug port request
	output logic                      O_CPU_STALL,       // Hold instruction flow
	output fpg_pkg::fpg_external_data_ram_s        O_EXTERNAL_DATA_RAM,            // Data RAM access
	output logic      [7:0]           O_CMOVE_RDATA,     // Code move read data
	output logic                      O_CMOVE_VALID,     // Code move data valid
	output logic                      O_DBG_DONE,        // Debug request finished
	output logic                      O_DBG_REFUSED,     // Debug request ignored
	output logic      [7:0]           O_DBG_RDATA,       // Debug read data
	output logic                      O_FLASH_ERROR_DEVICE_RESET             // Flash error reset request
);

	localparam int USER_BYTES = USER_PAGES * fpg_pkg::PAGE_BYTES;
	localparam int ALL_BYTES  = USER_BYTES + fpg_pkg::PAGE_BYTES;
	localparam int LOCK_IDX   = USER_BYTES - 1;
	localparam logic [fpg_pkg::FL_AW-1:0] LOCK_ADDR = fpg_pkg::FL_AW'(LOCK_IDX);
	localparam logic [fpg_pkg::FL_AW-1:0] LOCK_BASE = fpg_pkg::FL_AW'(USER_BYTES - 512);
	localparam logic [fpg_pkg::FL_AW-1:0] PAGE_LAST = fpg_pkg::FL_AW'(fpg_pkg::PAGE_BYTES - 1);
	localparam logic [fpg_pkg::FL_AW-1:0] USER_LAST = fpg_pkg::FL_AW'(USER_BYTES - 1);
	localparam logic [3:0] PROG_LAST = 4'(fpg_pkg::PROG_CYCLES - 1);

	// Array plus reserved page must fit the flash address width
	if (USER_PAGES < 1 || ALL_BYTES > (1 << fpg_pkg::FL_AW))
		$error("USER_PAGES out of range");

	typedef struct packed {
		logic                      avs_wait;
		logic [7:0]                avs_rdata;
		logic                      we;
		logic                      ee;
		fpg_pkg::fpg_key_e         key;
		logic                      mon_en;
		logic                      mon_rst;
		logic                      flag;
		logic                      flash_error_device_reset_pend;
		logic                      in_reset;
		logic                      lock_active;
		fpg_pkg::fpg_op_e          op;
		logic                      op_dbg;
		logic [fpg_pkg::FL_AW-1:0] op_addr;
		logic [fpg_pkg::FL_AW-1:0] cnt;
		logic [fpg_pkg::FL_AW-1:0] cnt_end;
		logic [7:0]                op_data;
		logic [3:0]                tmr;
		logic                      flash_error_device_reset;
		logic                      stall;
		fpg_pkg::fpg_external_data_ram_s        external_data_ram;
		logic [7:0]                cmove_rdata;
		logic                      cmove_valid;
		logic                      dbg_done;
		logic                      dbg_refused;
		logic [7:0]                dbg_rdata;
		fpg_pkg::fpg_fwr_s         fwr;
	} fpg_state_s;

	fpg_state_s                s_q;
	fpg_state_s                s_d;
	fpg_state_s                s_rst;
	logic [7:0]                rd_data;
	logic [7:0]                lock_byte;
	logic [fpg_pkg::FL_AW-1:0] rd_addr;
	logic [fpg_pkg::FL_AW-1:0] cpu_fa;
	logic [fpg_pkg::FL_AW-1:0] dbg_fa;
	logic                      ack;
	logic                      program_store_control_wr;
	logic                      key_wr;
	logic                      cpu_res;
	logic                      cpu_bad;
	logic                      cpu_start;
	logic                      dbg_res;
	logic                      dbg_take;
	logic                      dbg_refuse;
	logic                      exec_locked;

	fpg_flash_array #(
		.BYTES    (ALL_BYTES),
		.LOCK_IDX (LOCK_IDX)
	) u_array (
		.i_clk       (I_CORE_CLK),
		.i_por_n     (I_POR_N),
		.i_wr        (s_q.fwr),
		.i_rd_addr   (rd_addr),
		.o_rd_data   (rd_data),
		.o_lock_byte (lock_byte)
	);

	// Address classification for both requesters
	always_comb
	begin
		ack         = !s_q.avs_wait && (I_AVS_READ || I_AVS_WRITE);
		program_store_control_wr    = ack && I_AVS_WRITE && (I_AVS_ADDRESS == fpg_pkg::IDX_PROGRAM_STORE_CONTROL);
		key_wr      = ack && I_AVS_WRITE && (I_AVS_ADDRESS == fpg_pkg::IDX_KEY);
		cpu_fa      = I_CPU.addr[fpg_pkg::FL_AW-1:0];
		dbg_fa      = I_DBG.addr[fpg_pkg::FL_AW-1:0];
		cpu_res     = (int'(I_CPU.addr) >= USER_BYTES);
		dbg_res     = (int'(I_DBG.addr) >= USER_BYTES);
		exec_locked = s_q.lock_active && (int'(I_CPU.pc) < USER_BYTES);
		rd_addr     = (s_q.op != fpg_pkg::OP_IDLE) ? s_q.op_addr :
		              (I_CPU.crd ? cpu_fa : dbg_fa);
		// Firmware violations that turn into a flash error reset
		cpu_bad = 1'b0;
		if (I_CPU.xwr)
		begin
			cpu_bad = !s_q.mon_en || !s_q.mon_rst
			       || cpu_res
			       || (s_q.ee && (cpu_fa[fpg_pkg::FL_AW-1:9] == LOCK_BASE[fpg_pkg::FL_AW-1:9]))
			       || (s_q.lock_active && !exec_locked)
			       || (!s_q.ee && (cpu_fa == LOCK_ADDR) && (lock_byte != fpg_pkg::ERASED));
		end
		else if (I_CPU.crd)
		begin
			cpu_bad = cpu_res || (s_q.lock_active && !exec_locked);
		end
		cpu_start  = I_CPU.xwr && s_q.we && !cpu_bad && (s_q.key == fpg_pkg::KEY_OPEN)
		             && (s_q.op == fpg_pkg::OP_IDLE);
		// Debug takes the array only when the CPU leaves it alone
		// A pending array write must land first, or a debug read sees stale data
		dbg_take   = I_DBG.req && !s_q.dbg_done && (s_q.op == fpg_pkg::OP_IDLE)
		             && !s_q.fwr.en && !I_CPU.xwr && !I_CPU.crd;
		dbg_refuse = (I_DBG.cmd != fpg_pkg::DBG_DEVERASE)
		             && (dbg_res || s_q.lock_active);
	end

	// Values taken at system reset: cause flag and lock state are both latched here
	always_comb
	begin
		s_rst             = '0;
		s_rst.avs_wait    = 1'b1;
		s_rst.we          = fpg_pkg::PROGRAM_STORE_CONTROL_RST[fpg_pkg::WE_BIT];
		s_rst.ee          = fpg_pkg::PROGRAM_STORE_CONTROL_RST[fpg_pkg::EE_BIT];
		s_rst.key         = fpg_pkg::KEY_LOCKED;
		s_rst.mon_en      = fpg_pkg::SUPPLY_RST[fpg_pkg::MON_EN_BIT];
		s_rst.mon_rst     = fpg_pkg::SUPPLY_RST[fpg_pkg::MON_RST_BIT];
		s_rst.op          = fpg_pkg::OP_IDLE;
		s_rst.flag        = s_q.flash_error_device_reset_pend;
		s_rst.flash_error_device_reset_pend   = s_q.flash_error_device_reset_pend;    // Held so a long reset keeps the cause
		s_rst.in_reset    = 1'b1;
		s_rst.lock_active = (lock_byte != fpg_pkg::ERASED);
	end

	// Next state of the whole block
	always_comb
	begin
		s_d             = s_q;
		s_d.flash_error_device_reset        = 1'b0;
		s_d.dbg_done    = 1'b0;
		s_d.dbg_refused = 1'b0;
		s_d.cmove_valid = 1'b0;
		s_d.external_data_ram.wr     = 1'b0;
		s_d.external_data_ram.rd     = 1'b0;
		s_d.fwr.en      = 1'b0;
		s_d.in_reset    = 1'b0;
		// The cause is consumed by the reset just left; a new fault sets it again below
		if (s_q.in_reset)
			s_d.flash_error_device_reset_pend = 1'b0;

		// Register slave: one wait cycle, answer in the next
		s_d.avs_wait = !(s_q.avs_wait && (I_AVS_READ || I_AVS_WRITE));
		if (s_q.avs_wait)
		begin
			case (I_AVS_ADDRESS)
				fpg_pkg::IDX_PROGRAM_STORE_CONTROL:  s_d.avs_rdata = {6'h00, s_q.ee, s_q.we};
				fpg_pkg::IDX_KEY:    s_d.avs_rdata = {6'h00, s_q.key};
				fpg_pkg::IDX_RESET_SOURCE_REGISTER: s_d.avs_rdata = {7'h00, s_q.flag};
				fpg_pkg::IDX_SUPPLY: s_d.avs_rdata = {6'h00, s_q.mon_rst, s_q.mon_en};
				fpg_pkg::IDX_STATUS: s_d.avs_rdata = {6'h00, s_q.lock_active, s_q.op != fpg_pkg::OP_IDLE};
				default:             s_d.avs_rdata = 8'h00;
			endcase
		end
		if (program_store_control_wr)
		begin
			s_d.we = I_AVS_WRITEDATA[fpg_pkg::WE_BIT];
			s_d.ee = I_AVS_WRITEDATA[fpg_pkg::EE_BIT];
		end
		if (ack && I_AVS_WRITE && (I_AVS_ADDRESS == fpg_pkg::IDX_SUPPLY))
		begin
			s_d.mon_en  = I_AVS_WRITEDATA[fpg_pkg::MON_EN_BIT];
			s_d.mon_rst = I_AVS_WRITEDATA[fpg_pkg::MON_RST_BIT];
		end
		// Key sequence; a dead lock only lifts with reset
		if (key_wr)
		begin
			case (s_q.key)
				fpg_pkg::KEY_LOCKED:
					s_d.key = (I_AVS_WRITEDATA[7:0] == fpg_pkg::KEY_FIRST) ?
					          fpg_pkg::KEY_HALF : fpg_pkg::KEY_DEAD;
				fpg_pkg::KEY_HALF:
					s_d.key = (I_AVS_WRITEDATA[7:0] == fpg_pkg::KEY_SECOND) ?
					          fpg_pkg::KEY_OPEN : fpg_pkg::KEY_DEAD;
				default:
					s_d.key = fpg_pkg::KEY_DEAD;
			endcase
		end

		// CPU moves: external reads always go to data RAM, code reads go to the flash
		if (I_CPU.xrd)
		begin
			s_d.external_data_ram.rd   = 1'b1;
			s_d.external_data_ram.addr = I_CPU.addr;
		end
		if (I_CPU.xwr && !s_q.we)
		begin
			s_d.external_data_ram.wr   = 1'b1;
			s_d.external_data_ram.addr = I_CPU.addr;
			s_d.external_data_ram.data = I_CPU.data;
		end
		else if (I_CPU.xwr && cpu_bad)
		begin
			s_d.flash_error_device_reset      = 1'b1;
			s_d.flash_error_device_reset_pend = 1'b1;
		end
		else if (I_CPU.xwr && (s_q.key != fpg_pkg::KEY_OPEN))
		begin
			s_d.key = fpg_pkg::KEY_DEAD;
		end
		else if (cpu_start)
		begin
			s_d.key     = fpg_pkg::KEY_LOCKED;
			s_d.op_dbg  = 1'b0;
			s_d.op_data = I_CPU.data;
			s_d.cnt     = '0;
			s_d.tmr     = PROG_LAST;
			if (s_q.ee)
			begin
				s_d.op      = fpg_pkg::OP_ERASE;
				s_d.op_addr = {cpu_fa[fpg_pkg::FL_AW-1:9], 9'h000};
				s_d.cnt_end = PAGE_LAST;
			end
			else
			begin
				s_d.op      = fpg_pkg::OP_PROG;
				s_d.op_addr = cpu_fa;
			end
		end
		if (I_CPU.crd)
		begin
			if (cpu_bad)
			begin
				s_d.flash_error_device_reset      = 1'b1;
				s_d.flash_error_device_reset_pend = 1'b1;
			end
			else
			begin
				s_d.cmove_rdata = rd_data;
				s_d.cmove_valid = 1'b1;
			end
		end

		// Debug port: refusals are silent, never a reset
		if (dbg_take)
		begin
			s_d.op_dbg  = 1'b1;
			s_d.op_data = I_DBG.data;
			s_d.cnt     = '0;
			s_d.tmr     = PROG_LAST;
			if (dbg_refuse)
			begin
				s_d.dbg_done    = 1'b1;
				s_d.dbg_refused = 1'b1;
			end
			else
			begin
				case (I_DBG.cmd)
					fpg_pkg::DBG_READ:
					begin
						s_d.dbg_rdata = rd_data;
						s_d.dbg_done  = 1'b1;
					end
					fpg_pkg::DBG_WRITE:
					begin
						s_d.op      = fpg_pkg::OP_PROG;
						s_d.op_addr = dbg_fa;
					end
					fpg_pkg::DBG_ERASE:
					begin
						s_d.op      = fpg_pkg::OP_ERASE;
						s_d.op_addr = {dbg_fa[fpg_pkg::FL_AW-1:9], 9'h000};
						s_d.cnt_end = PAGE_LAST;
					end
					default:
					begin
						s_d.op      = fpg_pkg::OP_ERASE;
						s_d.op_addr = '0;
						s_d.cnt_end = USER_LAST;
					end
				endcase
			end
		end

		// Hardware-timed operation engine
		case (s_q.op)
			fpg_pkg::OP_PROG:
			begin
				if (s_q.tmr == 4'h0)
				begin
					s_d.fwr.en   = 1'b1;
					s_d.fwr.addr = s_q.op_addr;
					s_d.fwr.data = rd_data & s_q.op_data;
					s_d.op       = fpg_pkg::OP_IDLE;
					s_d.dbg_done = s_q.op_dbg;
				end
				else
				begin
					s_d.tmr = s_q.tmr - 4'h1;
				end
			end
			fpg_pkg::OP_ERASE:
			begin
				s_d.fwr.en   = 1'b1;
				s_d.fwr.addr = s_q.op_addr + s_q.cnt;
				s_d.fwr.data = fpg_pkg::ERASED;
				s_d.cnt      = s_q.cnt + fpg_pkg::FL_AW'(1);
				if (s_q.cnt == s_q.cnt_end)
				begin
					s_d.op       = fpg_pkg::OP_IDLE;
					s_d.dbg_done = s_q.op_dbg;
					if (s_q.cnt_end == USER_LAST)
						s_d.lock_active = 1'b0;
				end
			end
			default:
			begin
			end
		endcase

		// Stall also covers the cycle in which the last byte lands in the array
		s_d.stall = (s_d.op != fpg_pkg::OP_IDLE) || s_d.fwr.en;
	end

	// Power-on clears the cause flag; system reset keeps what it must
	always_ff @(posedge I_CORE_CLK)
	begin
		if (!I_POR_N)
		begin
			s_q           <= s_rst;
			s_q.flag      <= 1'b0;
			s_q.flash_error_device_reset_pend <= 1'b0;
		end
		else if (!I_RST_N)
			s_q <= s_rst;
		else
			s_q <= s_d;
	end

	assign O_AVS_READDATA    = {24'h000000, s_q.avs_rdata};
	assign O_AVS_WAITREQUEST = s_q.avs_wait;
	assign O_CPU_STALL       = s_q.stall;
	assign O_EXTERNAL_DATA_RAM            = s_q.external_data_ram;
	assign O_CMOVE_RDATA     = s_q.cmove_rdata;
	assign O_CMOVE_VALID     = s_q.cmove_valid;
	assign O_DBG_DONE        = s_q.dbg_done;
	assign O_DBG_REFUSED     = s_q.dbg_refused;
	assign O_DBG_RDATA       = s_q.dbg_rdata;
	assign O_FLASH_ERROR_DEVICE_RESET            = s_q.flash_error_device_reset;

	// Checks on the sequencer
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N || !I_POR_N);

	property p_we_sticky;
		s_q.we && !program_store_control_wr |=> s_q.we;
	endproperty
	a_we_sticky: assert property (p_we_sticky) else $error("write enable dropped");

	property p_key_open;
		key_wr && s_q.key == fpg_pkg::KEY_HALF && I_AVS_WRITEDATA[7:0] == fpg_pkg::KEY_SECOND
		&& !I_CPU.xwr |=> s_q.key == fpg_pkg::KEY_OPEN;
	endproperty
	a_key_open: assert property (p_key_open) else $error("key did not open");

	property p_key_dead;
		s_q.key == fpg_pkg::KEY_DEAD |=> s_q.key == fpg_pkg::KEY_DEAD;
	endproperty
	a_key_dead: assert property (p_key_dead) else $error("dead key recovered");

	property p_relock;
		cpu_start |=> s_q.key == fpg_pkg::KEY_LOCKED && s_q.stall;
	endproperty
	a_relock: assert property (p_relock) else $error("key not relocked or no stall");

	property p_monitor_off;
		I_CPU.xwr && s_q.we && (!s_q.mon_en || !s_q.mon_rst) |=> O_FLASH_ERROR_DEVICE_RESET ##1 !O_FLASH_ERROR_DEVICE_RESET;
	endproperty
	a_monitor_off: assert property (p_monitor_off) else $error("no error reset");

	property p_erase_ff;
		s_q.op == fpg_pkg::OP_ERASE |=> s_q.fwr.en && s_q.fwr.data == fpg_pkg::ERASED;
	endproperty
	a_erase_ff: assert property (p_erase_ff) else $error("erase wrote non blank");

	property p_prog_and;
		s_q.op == fpg_pkg::OP_PROG && s_q.tmr == 4'h0
		|=> s_q.fwr.en && s_q.fwr.data == ($past(rd_data) & s_q.op_data) && s_q.stall;
	endproperty
	a_prog_and: assert property (p_prog_and) else $error("program not an AND");

	property p_dbg_silent;
		dbg_take && dbg_refuse |=> O_DBG_REFUSED && O_DBG_DONE && !O_FLASH_ERROR_DEVICE_RESET;
	endproperty
	a_dbg_silent: assert property (p_dbg_silent) else $error("debug refusal wrong");

	property p_external_data_ram_read;
		I_CPU.xrd |=> O_EXTERNAL_DATA_RAM.rd && O_EXTERNAL_DATA_RAM.addr == $past(I_CPU.addr);
	endproperty
	a_external_data_ram_read: assert property (p_external_data_ram_read) else $error("move read missed data RAM");

	property p_external_data_ram_write;
		I_CPU.xwr && !s_q.we |=> O_EXTERNAL_DATA_RAM.wr && O_EXTERNAL_DATA_RAM.data == $past(I_CPU.data) && !O_FLASH_ERROR_DEVICE_RESET;
	endproperty
	a_external_data_ram_write: assert property (p_external_data_ram_write) else $error("move write missed data RAM");

endmodule : fpg_top
